//--- rtl/pcb_top.v
// Functional notes
// - the active compare-B value is compared with the counter every clock.
// - each compare-B match is handed to the action logic of both outputs.
// - an action is ignore, drive low, drive high or invert.
// - the compare-B mode select chooses shadowing, shadowed after reset.
// - with mode select 0 accesses to compare-B reach the shadow register.
// - in shadow mode the active value loads only on the chosen event.
// - a readable pending flag shows that the shadow register is occupied.
// - with mode select 1 accesses reach the active register directly.
// - active and shadow share one address, selected by the mode bit.
// - control bits 15-10 reserved, pending flags at 9 and 8, read-only.
// - mode bits at 6 and 4, load selects at 3-2 and 1-0, reset to zero.
// - load select 00 zero, 01 period, 10 either, 11 freeze.
// - a load clears the pending flag unless a write lands on the same edge; a pending write overwrites.
// - a load select does nothing while its channel is immediate.
// - compare-A matches and buffers the same way as compare-B.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defs.vh"

module pcb_top #(
   parameter WIDTH = 16
) (
   input  wire                    i_core_clk,
   input  wire                    i_reset,
   input  wire [`PCB_ADDR_W-1:0]  i_addr,
   input  wire [15:0]             i_wr_data,
   input  wire                    i_wr_en,
   input  wire                    i_rd_en,
   output reg  [15:0]             o_rd_data,
   input  wire [WIDTH-1:0]        i_time_base_count,
   input  wire [WIDTH-1:0]        i_time_base_period,
   output wire                    o_cmp_a_event,
   output wire                    o_cmp_b_event,
   output wire [WIDTH-1:0]        o_cmp_a_active,
   output wire [WIDTH-1:0]        o_cmp_b_active,
   output reg                     o_pwm_out_a,
   output reg                     o_pwm_out_b
);

   // compare control storage, writable bits only
   reg  [15:0]      compare_control;
   reg  [15:0]      action_cfg_a;
   reg  [15:0]      action_cfg_b;

   wire             chan_a_buffer_select;
   wire             chan_b_buffer_select;
   wire [1:0]       chan_a_load_select;
   wire [1:0]       chan_b_load_select;
   wire             chan_a_pending_flag;
   wire             chan_b_pending_flag;

   wire [WIDTH-1:0] compare_a_view;
   wire [WIDTH-1:0] compare_b_view;

   wire             wr_cmp_a;
   wire             wr_cmp_b;
   wire             wr_ctrl;
   wire             wr_act_a;
   wire             wr_act_b;

   reg  [15:0]      next_rd_data;
   reg              next_pwm_out_a;
   reg              next_pwm_out_b;

   // one-hot decode of a register index
   function hit;
      input [`PCB_ADDR_W-1:0] addr;
      input [`PCB_ADDR_W-1:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // apply one 2-bit action to a level
   function apply_action;
      input       level;
      input [1:0] action;
      begin
         case (action)
            `PCB_ACT_CLEAR:  apply_action = 1'b0;
            `PCB_ACT_SET:    apply_action = 1'b1;
            `PCB_ACT_TOGGLE: apply_action = ~level;
            default:         apply_action = level;
         endcase
      end
   endfunction

   // widen a 16-bit-or-less value for the read port
   function [15:0] to_word;
      input [WIDTH-1:0] value;
      begin
         to_word = 16'h0000;
         to_word[WIDTH-1:0] = value;
      end
   endfunction

   assign chan_a_buffer_select = compare_control[`PCB_CTL_A_MODE];
   assign chan_b_buffer_select = compare_control[`PCB_CTL_B_MODE];
   assign chan_a_load_select   =
      compare_control[`PCB_CTL_A_LOAD_HI:`PCB_CTL_A_LOAD_LO];
   assign chan_b_load_select   =
      compare_control[`PCB_CTL_B_LOAD_HI:`PCB_CTL_B_LOAD_LO];

   assign wr_cmp_a = i_wr_en & hit(i_addr, `PCB_ADDR_CMP_A);
   assign wr_cmp_b = i_wr_en & hit(i_addr, `PCB_ADDR_CMP_B);
   assign wr_ctrl  = i_wr_en & hit(i_addr, `PCB_ADDR_CTRL);
   assign wr_act_a = i_wr_en & hit(i_addr, `PCB_ADDR_ACT_A);
   assign wr_act_b = i_wr_en & hit(i_addr, `PCB_ADDR_ACT_B);

   pcb_compare_chan #(
      .WIDTH           (WIDTH)
   ) u_chan_a (
      .i_core_clk      (i_core_clk),
      .i_reset         (i_reset),
      .i_buffer_select (chan_a_buffer_select),
      .i_load_select   (chan_a_load_select),
      .i_wr            (wr_cmp_a),
      .i_wdata         (i_wr_data[WIDTH-1:0]),
      .i_count         (i_time_base_count),
      .i_period        (i_time_base_period),
      .o_view          (compare_a_view),
      .o_active        (o_cmp_a_active),
      .o_pending       (chan_a_pending_flag),
      .o_match         (o_cmp_a_event)
   );

   pcb_compare_chan #(
      .WIDTH           (WIDTH)
   ) u_chan_b (
      .i_core_clk      (i_core_clk),
      .i_reset         (i_reset),
      .i_buffer_select (chan_b_buffer_select),
      .i_load_select   (chan_b_load_select),
      .i_wr            (wr_cmp_b),
      .i_wdata         (i_wr_data[WIDTH-1:0]),
      .i_count         (i_time_base_count),
      .i_period        (i_time_base_period),
      .o_view          (compare_b_view),
      .o_active        (o_cmp_b_active),
      .o_pending       (chan_b_pending_flag),
      .o_match         (o_cmp_b_event)
   );

   // configuration registers
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         compare_control <= `PCB_RST_CTRL;
         action_cfg_a    <= `PCB_RST_ACT;
         action_cfg_b    <= `PCB_RST_ACT;
      end else begin
         // flags and reserved bits not writable
         if (wr_ctrl)
            compare_control <= i_wr_data & `PCB_CTL_WR_MASK;
         if (wr_act_a)
            action_cfg_a <= i_wr_data & `PCB_ACT_WR_MASK;
         if (wr_act_b)
            action_cfg_b <= i_wr_data & `PCB_ACT_WR_MASK;
      end
   end

   // read mux, answer lands the cycle after the strobe
   always @* begin
      next_rd_data = 16'h0000;
      if (i_rd_en) begin
         case (i_addr)
            `PCB_ADDR_CMP_A:
               next_rd_data = to_word(compare_a_view);
            `PCB_ADDR_CMP_B:
               next_rd_data = to_word(compare_b_view);
            `PCB_ADDR_CTRL: begin
               next_rd_data = compare_control;
               // flags live in bits 9 and 8
               next_rd_data[`PCB_CTL_B_FULL] = chan_b_pending_flag;
               next_rd_data[`PCB_CTL_A_FULL] = chan_a_pending_flag;
            end
            `PCB_ADDR_ACT_A:
               next_rd_data = action_cfg_a;
            `PCB_ADDR_ACT_B:
               next_rd_data = action_cfg_b;
            `PCB_ADDR_STATUS:
               next_rd_data = {12'h000, o_cmp_b_event, o_cmp_a_event,
                               o_pwm_out_b, o_pwm_out_a};
            default:
               next_rd_data = 16'h0000;
         endcase
      end
   end

   // action qualifier: compare-A first, compare-B applied last so it wins
   always @* begin
      next_pwm_out_a = o_pwm_out_a;
      next_pwm_out_b = o_pwm_out_b;
      if (o_cmp_a_event) begin
         next_pwm_out_a = apply_action(next_pwm_out_a,
            action_cfg_a[`PCB_ACT_CA_LO+1:`PCB_ACT_CA_LO]);
         next_pwm_out_b = apply_action(next_pwm_out_b,
            action_cfg_b[`PCB_ACT_CA_LO+1:`PCB_ACT_CA_LO]);
      end
      if (o_cmp_b_event) begin
         next_pwm_out_a = apply_action(next_pwm_out_a,
            action_cfg_a[`PCB_ACT_CB_LO+1:`PCB_ACT_CB_LO]);
         next_pwm_out_b = apply_action(next_pwm_out_b,
            action_cfg_b[`PCB_ACT_CB_LO+1:`PCB_ACT_CB_LO]);
      end
   end

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_rd_data   <= 16'h0000;
         o_pwm_out_a <= 1'b0;
         o_pwm_out_b <= 1'b0;
      end else begin
         o_rd_data   <= next_rd_data;
         o_pwm_out_a <= next_pwm_out_a;
         o_pwm_out_b <= next_pwm_out_b;
      end
   end

endmodule // pcb_top

`default_nettype wire

//--- pkg/pcb_defs.vh
`ifndef PCB_DEFS_VH
`define PCB_DEFS_VH

// register indices on the plain register port
`define PCB_ADDR_W          4
`define PCB_ADDR_CMP_A      4'h0
`define PCB_ADDR_CMP_B      4'h1
`define PCB_ADDR_CTRL       4'h2
`define PCB_ADDR_ACT_A      4'h3
`define PCB_ADDR_ACT_B      4'h4
`define PCB_ADDR_STATUS     4'h5

// compare control field positions
`define PCB_CTL_B_FULL      9
`define PCB_CTL_A_FULL      8
`define PCB_CTL_B_MODE      6
`define PCB_CTL_A_MODE      4
`define PCB_CTL_B_LOAD_HI   3
`define PCB_CTL_B_LOAD_LO   2
`define PCB_CTL_A_LOAD_HI   1
`define PCB_CTL_A_LOAD_LO   0
`define PCB_CTL_WR_MASK     16'h005f

// load select encodings
`define PCB_LOAD_ZERO       2'h0
`define PCB_LOAD_PRD        2'h1
`define PCB_LOAD_EITHER     2'h2
`define PCB_LOAD_FREEZE     2'h3

// buffer select encodings
`define PCB_MODE_SHADOW     1'b0
`define PCB_MODE_IMMEDIATE  1'b1

// action encodings
`define PCB_ACT_NONE        2'h0
`define PCB_ACT_CLEAR       2'h1
`define PCB_ACT_SET         2'h2
`define PCB_ACT_TOGGLE      2'h3

// action config field positions
`define PCB_ACT_CA_LO       0
`define PCB_ACT_CB_LO       2
`define PCB_ACT_WR_MASK     16'h000f

// reset values
`define PCB_RST_VALUE       16'h0000
`define PCB_RST_CTRL        16'h0000
`define PCB_RST_ACT         16'h0000

`endif

//--- rtl/pcb_compare_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defs.vh"

module pcb_compare_chan #(
   parameter WIDTH = 16
) (
   input  wire             i_core_clk,
   input  wire             i_reset,
   input  wire             i_buffer_select,
   input  wire [1:0]       i_load_select,
   input  wire             i_wr,
   input  wire [WIDTH-1:0] i_wdata,
   input  wire [WIDTH-1:0] i_count,
   input  wire [WIDTH-1:0] i_period,
   output wire [WIDTH-1:0] o_view,
   output reg  [WIDTH-1:0] o_active,
   output reg              o_pending,
   output reg              o_match
);

   reg  [WIDTH-1:0] shadow;
   wire             at_zero;
   wire             at_period;
   reg              load_strobe;

   assign at_zero   = (i_count == {WIDTH{1'b0}});
   assign at_period = (i_count == i_period);

   always @* begin
      case (i_load_select)
         `PCB_LOAD_ZERO:   load_strobe = at_zero;
         `PCB_LOAD_PRD:    load_strobe = at_period;
         `PCB_LOAD_EITHER: load_strobe = at_zero | at_period;
         default:          load_strobe = 1'b0;
      endcase
   end

   assign o_view = (i_buffer_select == `PCB_MODE_IMMEDIATE) ? o_active
                                                            : shadow;

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         shadow    <= `PCB_RST_VALUE;
         o_active  <= `PCB_RST_VALUE;
         o_pending <= 1'b0;
         o_match   <= 1'b0;
      end else begin
         o_match <= (i_count == o_active);
         if (i_buffer_select == `PCB_MODE_IMMEDIATE) begin
            if (i_wr)
               o_active <= i_wdata;
         end else begin
            if (load_strobe)
               o_active <= shadow;
            if (i_wr)
               shadow <= i_wdata;
         end
         if (i_wr && i_buffer_select == `PCB_MODE_SHADOW)
            o_pending <= 1'b1;
         else if (load_strobe && i_buffer_select == `PCB_MODE_SHADOW)
            o_pending <= 1'b0;
      end
   end

endmodule // pcb_compare_chan

`default_nettype wire

//--- tb/pcb_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defs.vh"
module pcb_top_asserts #(
   parameter WIDTH = 16
) (
   input wire logic             i_core_clk,
   input wire logic             i_reset,
   input wire logic [3:0]       i_addr,
   input wire logic [15:0]      i_wr_data,
   input wire logic             i_wr_en,
   input wire logic             i_rd_en,
   input wire logic [15:0]      o_rd_data,
   input wire logic [WIDTH-1:0] i_time_base_count,
   input wire logic [WIDTH-1:0] i_time_base_period,
   input wire logic             o_cmp_a_event,
   input wire logic             o_cmp_b_event,
   input wire logic [WIDTH-1:0] o_cmp_a_active,
   input wire logic [WIDTH-1:0] o_cmp_b_active
);
   // mirror of the b buffer select, taken from control writes
   logic b_mode;
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         b_mode <= 1'b0;
      end else if (i_wr_en && i_addr == `PCB_ADDR_CTRL) begin
         b_mode <= i_wr_data[`PCB_CTL_B_MODE];
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   sequence s_b_wr;
      i_wr_en && i_addr == `PCB_ADDR_CMP_B;
   endsequence
   sequence s_ctl_rd;
      i_rd_en && i_addr == `PCB_ADDR_CTRL;
   endsequence
   property p_b_match;
      i_time_base_count == o_cmp_b_active |=> o_cmp_b_event;
   endproperty
   a_b_match: assert property (p_b_match)
      else $error("b event missing");
   property p_b_quiet;
      i_time_base_count != o_cmp_b_active |=> !o_cmp_b_event;
   endproperty
   a_b_quiet: assert property (p_b_quiet)
      else $error("b event without match");
   property p_a_match;
      i_time_base_count == o_cmp_a_active |=> o_cmp_a_event;
   endproperty
   a_a_match: assert property (p_a_match)
      else $error("a event missing");
   property p_b_imm;
      s_b_wr ##0 b_mode |=> o_cmp_b_active == $past(i_wr_data);
   endproperty
   a_b_imm: assert property (p_b_imm)
      else $error("immediate write missed active");
   // no load event, so a shadowed active value cannot move
   property p_b_hold;
      !b_mode && i_time_base_count != 16'h0000
         && i_time_base_count != i_time_base_period
         |=> $stable(o_cmp_b_active);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("active b moved without load");
   property p_ctl_rsvd;
      s_ctl_rd |=> o_rd_data[15:10] == 6'h00 && !o_rd_data[7]
         && !o_rd_data[5];
   endproperty
   a_ctl_rsvd: assert property (p_ctl_rsvd)
      else $error("reserved control bit set");
   property p_ctl_mode;
      s_ctl_rd |=> o_rd_data[`PCB_CTL_B_MODE] == $past(b_mode);
   endproperty
   a_ctl_mode: assert property (p_ctl_mode)
      else $error("b buffer select read wrong");
   property p_b_imm_rd;
      i_rd_en && i_addr == `PCB_ADDR_CMP_B && b_mode
         |=> o_rd_data == $past(o_cmp_b_active);
   endproperty
   a_b_imm_rd: assert property (p_b_imm_rd)
      else $error("immediate read not active value");
endmodule // pcb_top_asserts
`default_nettype wire

//--- tb/pcb_tb_time_base.sv
`timescale 1ns/1ps
`default_nettype none
module pcb_tb_time_base (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_run,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_value,
   input  wire logic [15:0] i_period,
   output var  logic [15:0] o_count
);
   // up-count only; a load wins so the bench can park the count
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_count <= 16'h0000;
      end else if (i_load) begin
         o_count <= i_load_value;
      end else if (i_run) begin
         o_count <= (o_count == i_period) ? 16'h0000 : o_count + 16'h0001;
      end
   end
endmodule // pcb_tb_time_base
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defs.vh"
module tb_top;
   logic        i_core_clk, i_reset, i_wr_en, i_rd_en, run, load;
   logic        o_cmp_a_event, o_cmp_b_event, o_pwm_out_a, o_pwm_out_b;
   logic [3:0]  i_addr;
   logic [15:0] i_wr_data, o_rd_data, i_time_base_count, o_cmp_a_active;
   logic [15:0] i_time_base_period, o_cmp_b_active, load_val, exp_b;
   logic [1:0]  acts [4];
   logic        exp_pa, exp_pb;
   int          num_errors, samples_checked, i, j;
   pcb_top DUT (.*);
   pcb_tb_time_base u_cnt (.i_core_clk(i_core_clk), .i_reset(i_reset),
      .i_run(run), .i_load(load), .i_load_value(load_val),
      .i_period(i_time_base_period), .o_count(i_time_base_count));
   task automatic chk(input string n, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, string n);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_core_clk);
      i_rd_en <= 1'b0;
      #1;
      chk(n, e, o_rd_data);
   endtask
   // one clock of count v, then back to the parking value
   task automatic pulse(input logic [15:0] v);
      @(posedge i_core_clk);
      load_val <= v;
      @(posedge i_core_clk);
      load_val <= 16'h0005;
      @(posedge i_core_clk);
      #1;
   endtask
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   initial begin
      repeat (20000) @(posedge i_core_clk);
      num_errors++;
      results();
   end
   initial begin
      i_reset = 1'b1;
      {i_addr, i_wr_data, i_wr_en, i_rd_en, run} = '0;
      {load, load_val, i_time_base_period} = {1'b1, 16'h0005, 16'h0020};
      acts = '{`PCB_ACT_SET, `PCB_ACT_NONE, `PCB_ACT_CLEAR, `PCB_ACT_TOGGLE};
      repeat (4) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rd(`PCB_ADDR_CTRL, `PCB_RST_CTRL, "ctrl reset");
      rd(4'hf, 16'h0000, "unmapped");
      wr(`PCB_ADDR_CTRL, 16'hffff);
      rd(`PCB_ADDR_CTRL, 16'h005f, "ctrl mask");
      wr(`PCB_ADDR_CTRL, 16'h0000);
      wr(`PCB_ADDR_CMP_B, 16'h0010);
      chk("shadow active", 16'h0000, o_cmp_b_active);
      rd(`PCB_ADDR_CTRL, 16'h0200, "b pending");
      wr(`PCB_ADDR_CMP_B, 16'h0012);
      rd(`PCB_ADDR_CMP_B, 16'h0012, "b overwrite");
      @(posedge i_core_clk);
      {load, run} <= 2'b01;
      #1;
      for (i = 0; i < 64 && o_cmp_b_active !== 16'h0012; i++) #10;
      chk("zero load", 16'h0012, o_cmp_b_active);
      if (i == 64) results();
      rd(`PCB_ADDR_CTRL, 16'h0000, "b flag clear");
      @(posedge i_core_clk);
      load <= 1'b1;
      exp_b = 16'h0012;
      for (i = 0; i < 4; i++) begin
         wr(`PCB_ADDR_CTRL, 16'(i << 2));
         for (j = 0; j < 2; j++) begin
            wr(`PCB_ADDR_CMP_B, 16'h0100 + 16'(i * 2 + j));
            pulse(j == 1 ? i_time_base_period : 16'h0000);
            if (i == 2 || i == j) exp_b = 16'h0100 + 16'(i * 2 + j);
            chk("load select", exp_b, o_cmp_b_active);
         end
      end
      wr(`PCB_ADDR_CTRL, 16'h0040);
      wr(`PCB_ADDR_CMP_B, 16'h0007);
      chk("imm active", 16'h0007, o_cmp_b_active);
      rd(`PCB_ADDR_CMP_B, 16'h0007, "imm read");
      pulse(16'h0000);
      chk("imm no load", 16'h0007, o_cmp_b_active);
      wr(`PCB_ADDR_ACT_A, 16'h000c);
      {exp_pa, exp_pb} = 2'b00;
      for (i = 0; i < 4; i++) begin
         wr(`PCB_ADDR_ACT_B, {12'h000, acts[i], 2'b00});
         pulse(16'h0007);
         chk("b event", 16'h0001, {15'h0000, o_cmp_b_event});
         @(posedge i_core_clk);
         #1;
         exp_pa = ~exp_pa;
         case (acts[i])
            `PCB_ACT_SET: exp_pb = 1'b1;
            `PCB_ACT_CLEAR: exp_pb = 1'b0;
            `PCB_ACT_TOGGLE: exp_pb = ~exp_pb;
            default: exp_pb = exp_pb;
         endcase
         chk("pwm", {14'h0, exp_pa, exp_pb}, {14'h0, o_pwm_out_a,
            o_pwm_out_b});
         chk("b pulse", 16'h0000, {15'h0000, o_cmp_b_event});
      end
      // action config keeps only its low four bits
      wr(`PCB_ADDR_ACT_A, 16'hfff2);
      rd(`PCB_ADDR_ACT_A, 16'h0002, "act a mask");
      rd(`PCB_ADDR_ACT_B, {12'h000, `PCB_ACT_TOGGLE, 2'b00}, "act b");
      // b flag still held from the frozen writes, a now pending
      wr(`PCB_ADDR_CMP_A, 16'h0009);
      chk("a shadow active", 16'h0000, o_cmp_a_active);
      rd(`PCB_ADDR_CTRL, 16'h0340, "a pending");
      pulse(16'h0000);
      chk("a zero load", 16'h0009, o_cmp_a_active);
      chk("a event", 16'h0001, {15'h0000, o_cmp_a_event});
      @(posedge i_core_clk);
      #1;
      chk("pwm a event", 16'h0003, {o_pwm_out_a, o_pwm_out_b});
      rd(`PCB_ADDR_STATUS, 16'h0003, "status");
      rd(`PCB_ADDR_CTRL, 16'h0240, "a flag clear");
      // write lands on the same edge as the zero load
      fork
         pulse(16'h0000);
         begin
            @(posedge i_core_clk);
            wr(`PCB_ADDR_CMP_A, 16'h000b);
         end
      join
      chk("a load beside write", 16'h0009, o_cmp_a_active);
      rd(`PCB_ADDR_CTRL, 16'h0340, "set wins");
      rd(`PCB_ADDR_CMP_A, 16'h000b, "a shadow read");
      // both events in one clock, the b action is applied last
      wr(`PCB_ADDR_CTRL, 16'h0050);
      wr(`PCB_ADDR_CMP_A, 16'h0030);
      wr(`PCB_ADDR_CMP_B, 16'h0030);
      wr(`PCB_ADDR_ACT_A, 16'h0006);
      wr(`PCB_ADDR_ACT_B, 16'h0009);
      pulse(16'h0030);
      chk("both events", 16'h0003, {o_cmp_a_event, o_cmp_b_event});
      @(posedge i_core_clk);
      #1;
      chk("b wins", 16'h0001, {o_pwm_out_a, o_pwm_out_b});
      results();
   end
endmodule // tb_top
bind pcb_top pcb_top_asserts #(.WIDTH(WIDTH)) u_asserts (.*);
`default_nettype wire
